// *** design/srh_pkg.sv ***
package srh_pkg;

  // ==========================================================================
  // Register bus
  localparam int        DW          = 16;
  localparam int        AW          = 3;
  localparam logic [2:0] A_CTRL0    = 3'h0;
  localparam logic [2:0] A_CTRL1    = 3'h1;
  localparam logic [2:0] A_CTRL2    = 3'h2;
  localparam logic [2:0] A_IRQEN    = 3'h3;
  localparam logic [2:0] A_STAT1    = 3'h4;
  localparam logic [2:0] A_STAT4    = 3'h5;

  // ==========================================================================
  // Control register 0 fields
  localparam int RUN_CUR_LSB   = 0;
  localparam int HOLD_CUR_LSB  = 4;
  localparam int RH_POL_BIT    = 8;
  localparam int DIR_POL_BIT   = 9;
  localparam int MODE_LSB      = 10;
  localparam int SOFT_STEP_BIT = 13;
  localparam int MOTOR_ENABLE_BIT_BIT     = 14;
  localparam int BOOST_BIT     = 15;

  // Control register 1 and 2 fields
  localparam int UV1_IDX_LSB   = 0;
  localparam int UV2_IDX_LSB   = 4;
  localparam int STTO_LSB      = 8;
  localparam int STTHR_LSB     = 0;
  localparam int ENH_BIT       = 4;
  localparam int GAIN_BIT      = 5;
  localparam int SPTHR_LSB     = 8;

  // Interrupt enable bits
  localparam int IE_UV1  = 0;
  localparam int IE_UV2  = 1;
  localparam int IE_UV2M = 2;
  localparam int IE_UV3  = 3;
  localparam int IE_UV3M = 4;
  localparam int IE_EMF  = 5;

  // ==========================================================================
  // Reset values and step geometry
  localparam logic [15:0] CTRL0_RST   = 16'h0000;
  localparam logic [15:0] CTRL1_RST   = 16'h0000;
  localparam logic [15:0] CTRL2_RST   = 16'h0000;
  localparam logic [5:0]  IRQEN_RST   = 6'h00;
  localparam logic [6:0]  POS_RST     = 7'h00;
  localparam logic [2:0]  MODE_FS1A   = 3'h5;
  localparam logic [2:0]  MODE_FS1B   = 3'h6;
  localparam logic [6:0]  FULL_STEP   = 7'h20;
  localparam logic [6:0]  BACK_135    = 7'h30;
  localparam logic [6:0]  LOSS_MAX    = 7'h7f;
  localparam logic [1:0]  STALL_HITS  = 2'h2;
  localparam int          STTO_UNIT   = 4;

  // ==========================================================================
  // Back-EMF sample from the analogue front end
  typedef struct packed {
    logic       valid;
    logic       discard;
    logic       sign_bad;
    logic       coil;
    logic [4:0] code;
  } srh_emf_t;

endpackage : srh_pkg

// *** design/srh_supervisor.sv ***
`timescale 1ns/1ns
// What this block does
// - Run mode is run/hold pin XOR polarity bit while sleep is low; otherwise hold.
// - Run mode steps the translator and uses the run current field.
// - Hold mode ignores steps and direction, keeps position, uses hold current.
// - Direction, step mode and soft step in one write: step uses new settings.
// - Boost only raises boost_active_o, coil_amp_o unscaled; auto-off above thermal warning; status readable.
// - Hold current zero disables detection and reports zero duty.
// - New run or hold current applies at the next PWM period.
// - Motor disabled still steps logic; sleep blocks it; pin readable.
// - Three undervoltage levels, two indexed, each with flag and enable.
// - All enabled sources merge onto one error output.
// - Level one only pulls error low if enabled; no bridge action.
// - Level two/three motion enable: steps blocked, error low, steps counted.
// - Level three clears motor enable; re-enable only when its flag is zero.
// - Step loss counter saturates at 127; ignores direction and mode changes.
// - Sample EMF in zero crossing, drop discarded samples, flag result ready.
// - Normal mode keeps last sample at phase end; enhanced updates continuously.
// - Timeout in four-period units forces evaluation; zero disables it.
// - Two low results in run: stall flag, 135 degree backstep, error low.
// - Status one read clears stall; steps resume after a direction toggle.
// - Hold at single-coil full step: EMF at or above threshold flags stall.
// - Measurement and detection only while speed is at or below threshold.
// - Sign flag, last code and sampled coil are readable.
module srh_supervisor (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [2:0]         addr_i,
  input  wire logic [15:0]        wdata_i,
  input  wire logic               we_i,
  input  wire logic               re_i,
  output logic      [15:0]        rdata_o,
  input  wire logic               run_hold_pin_i,
  input  wire logic               step_pulse_pin_i,
  input  wire logic               dir_pin_i,
  input  wire logic [2:0]         uv_level_i,
  input  wire logic               thermal_warn_i,
  input  wire logic               sleep_i,
  input  wire logic               pwm_period_i,
  input  wire logic               zc_active_i,
  input  wire srh_pkg::srh_emf_t  emf_i,
  input  wire logic [7:0]         measured_speed_i,
  input  wire logic               error_out_n_i,
  output logic                    error_out_n_o,
  output logic                    error_out_n_oe_o,
  output logic [6:0]              position_o,
  output logic [3:0]              coil_amp_o,
  output logic                    boost_active_o,
  output logic                    bridge_en_o,
  output logic                    duty_zero_o,
  output logic [3:0]              uv1_index_o,
  output logic [3:0]              uv2_index_o,
  output logic                    emf_gain_select_o
);

  // ==========================================================================
  // Pin synchronisers
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_reg;
  logic [NSYNC-1:0] sync_reg;

  assign async_in = {thermal_warn_i, uv_level_i, dir_pin_i, step_pulse_pin_i, run_hold_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= async_in[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  logic       rh_pin;
  logic       step_pin;
  logic       dir_pin;
  logic [2:0] uv_live;
  logic       tw_live;

  assign rh_pin   = sync_reg[0];
  assign step_pin = sync_reg[1];
  assign dir_pin  = sync_reg[2];
  assign uv_live  = sync_reg[5:3];
  assign tw_live  = sync_reg[6];

  // Error wire idles high, so its read-back flops reset high
  logic err_meta_reg;
  logic err_wire_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_meta_reg <= 1'b1;
      err_wire_reg <= 1'b1;
    end else begin
      err_meta_reg <= error_out_n_i;
      err_wire_reg <= err_meta_reg;
    end
  end

  // ==========================================================================
  // Register file
  logic [15:0] ctrl0_reg;
  logic [15:0] ctrl1_reg;
  logic [15:0] ctrl2_reg;
  logic [5:0]  irqen_reg;
  logic        soft_step_reg;
  logic        motor_en_reg;
  logic [2:0]  uv_flag_reg;
  logic        stall_reg;
  logic        lose_reg;
  logic        ready_reg;
  logic [6:0]  loss_cnt_reg;
  logic [4:0]  emf_code_reg;
  logic        emf_sign_reg;
  logic        emf_coil_reg;
  logic        boost_reg;

  logic wr_ctrl0;
  logic rd_stat1;
  logic rd_stat4;

  assign wr_ctrl0 = we_i && (addr_i == srh_pkg::A_CTRL0);
  assign rd_stat1 = re_i && (addr_i == srh_pkg::A_STAT1);
  assign rd_stat4 = re_i && (addr_i == srh_pkg::A_STAT4);

  logic [3:0] run_cur;
  logic [3:0] hold_cur;
  logic       rh_pol;
  logic       dir_pol;
  logic [2:0] step_mode;
  logic [7:0] stall_timeout;
  logic [3:0] stall_threshold;
  logic       enhanced_emf_mode;
  logic [7:0] speed_threshold;

  assign run_cur           = ctrl0_reg[srh_pkg::RUN_CUR_LSB +: 4];
  assign hold_cur          = ctrl0_reg[srh_pkg::HOLD_CUR_LSB +: 4];
  assign rh_pol            = ctrl0_reg[srh_pkg::RH_POL_BIT];
  assign dir_pol           = ctrl0_reg[srh_pkg::DIR_POL_BIT];
  assign step_mode         = ctrl0_reg[srh_pkg::MODE_LSB +: 3];
  assign stall_timeout     = ctrl1_reg[srh_pkg::STTO_LSB +: 8];
  assign stall_threshold   = ctrl2_reg[srh_pkg::STTHR_LSB +: 4];
  assign enhanced_emf_mode = ctrl2_reg[srh_pkg::ENH_BIT];
  assign speed_threshold   = ctrl2_reg[srh_pkg::SPTHR_LSB +: 8];

  // Soft step and motor enable live in their own flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl0_reg <= srh_pkg::CTRL0_RST;
      ctrl1_reg <= srh_pkg::CTRL1_RST;
      ctrl2_reg <= srh_pkg::CTRL2_RST;
      irqen_reg <= srh_pkg::IRQEN_RST;
    end else if (we_i) begin
      unique case (addr_i)
        srh_pkg::A_CTRL0: ctrl0_reg <= wdata_i;
        srh_pkg::A_CTRL1: ctrl1_reg <= wdata_i;
        srh_pkg::A_CTRL2: ctrl2_reg <= wdata_i;
        srh_pkg::A_IRQEN: irqen_reg <= wdata_i[5:0];
        default: ;
      endcase
    end
  end

  // Written settings land this edge, so the queued step uses them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_step_reg <= 1'b0;
    end else begin
      soft_step_reg <= wr_ctrl0 && wdata_i[srh_pkg::SOFT_STEP_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      motor_en_reg <= 1'b0;
    end else if (uv_live[2]) begin
      motor_en_reg <= 1'b0;
    end else if (wr_ctrl0) begin
      motor_en_reg <= wdata_i[srh_pkg::MOTOR_ENABLE_BIT_BIT] && !uv_flag_reg[2];
    end
  end

  // ==========================================================================
  // Mode, direction and step triggers
  logic run_mode;
  logic direction;
  logic step_pin_d_reg;
  logic dir_d_reg;
  logic trig;
  logic uv_block;
  logic step_ok;
  logic step_lost;

  assign run_mode  = (rh_pin ^ rh_pol) && !sleep_i;
  assign direction = dir_pin ^ dir_pol;
  assign trig      = (step_pin && !step_pin_d_reg) || soft_step_reg;
  assign uv_block  = (uv_live[1] && irqen_reg[srh_pkg::IE_UV2M])
                   || (uv_live[2] && irqen_reg[srh_pkg::IE_UV3M]);

  logic dir_wait_reg;
  assign step_ok   = trig && run_mode && !uv_block && !stall_reg && !dir_wait_reg;
  assign step_lost = trig && run_mode && uv_block;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_pin_d_reg <= 1'b0;
      dir_d_reg      <= 1'b0;
    end else begin
      step_pin_d_reg <= step_pin;
      dir_d_reg      <= direction;
    end
  end

  logic [6:0] step_size;
  assign step_size = (step_mode >= srh_pkg::MODE_FS1A) ? srh_pkg::FULL_STEP
                   : 7'(7'h01 << step_mode);

  // ==========================================================================
  // Back-EMF capture and stall detection
  logic       zc_d_reg;
  logic [9:0] to_cnt_reg;
  logic       to_done_reg;
  logic       measure_ok;
  logic       det_en;
  logic       smp;
  logic       zc_end;
  logic       to_fire;
  logic       eval;
  logic [4:0] last_code_reg;
  logic       last_sign_reg;
  logic       last_coil_reg;
  logic [1:0] low_cnt_reg;
  logic       below;
  logic       stall_run_evt;
  logic       stall_hold_evt;
  logic [9:0] to_limit;

  localparam int STTO_UNIT = srh_pkg::STTO_UNIT; // PWM periods per timeout unit

  assign measure_ok = (measured_speed_i <= speed_threshold) && !sleep_i;
  assign det_en     = (stall_threshold != 4'h0) && !(!run_mode && hold_cur == 4'h0);
  assign smp        = emf_i.valid && !emf_i.discard && zc_active_i && measure_ok;
  assign zc_end     = zc_d_reg && !zc_active_i;
  assign to_limit   = 10'(stall_timeout * STTO_UNIT);
  assign to_fire    = (stall_timeout != 8'h00) && zc_active_i && pwm_period_i
                   && !to_done_reg && (to_cnt_reg + 10'h001 == to_limit);
  assign eval       = measure_ok && ((zc_end && !to_done_reg) || to_fire);
  assign below      = last_code_reg[4:1] < stall_threshold;
  assign stall_run_evt  = eval && run_mode && det_en && below
                       && (low_cnt_reg == srh_pkg::STALL_HITS - 2'h1) && !stall_reg;
  assign stall_hold_evt = eval && !run_mode && det_en && !sleep_i
                       && ((step_mode == srh_pkg::MODE_FS1A) || (step_mode == srh_pkg::MODE_FS1B))
                       && (position_o[4:0] == 5'h00) && !below;

  // Timeout counts PWM periods inside one zero-crossing phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      zc_d_reg    <= 1'b0;
      to_cnt_reg  <= 10'h000;
      to_done_reg <= 1'b0;
    end else begin
      zc_d_reg <= zc_active_i;
      if (!zc_active_i) begin
        to_cnt_reg  <= 10'h000;
        to_done_reg <= 1'b0;
      end else if (pwm_period_i) begin
        to_cnt_reg  <= to_cnt_reg + 10'h001;
        to_done_reg <= to_done_reg || to_fire;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_code_reg <= 5'h00;
      last_sign_reg <= 1'b0;
      last_coil_reg <= 1'b0;
    end else if (smp) begin
      last_code_reg <= emf_i.code;
      last_sign_reg <= emf_i.sign_bad;
      last_coil_reg <= emf_i.coil;
    end
  end

  // Enhanced mode exposes every kept sample; normal mode only the final one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      emf_code_reg <= 5'h00;
      emf_sign_reg <= 1'b0;
      emf_coil_reg <= 1'b0;
    end else if (enhanced_emf_mode && smp) begin
      emf_code_reg <= emf_i.code;
      emf_sign_reg <= emf_i.sign_bad;
      emf_coil_reg <= emf_i.coil;
    end else if (!enhanced_emf_mode && eval) begin
      emf_code_reg <= last_code_reg;
      emf_sign_reg <= last_sign_reg;
      emf_coil_reg <= last_coil_reg;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= eval || (enhanced_emf_mode && smp) || (ready_reg && !rd_stat4);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt_reg <= 2'h0;
    end else if (eval && run_mode && det_en) begin
      low_cnt_reg <= (below && !stall_run_evt) ? low_cnt_reg + 2'h1 : 2'h0;
    end
  end

  // Set beats the clearing read
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stall_reg <= 1'b0;
    end else begin
      stall_reg <= stall_run_evt || stall_hold_evt || (stall_reg && !rd_stat1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dir_wait_reg <= 1'b0;
    end else if (stall_run_evt || stall_hold_evt) begin
      dir_wait_reg <= 1'b1;
    end else if (!stall_reg && direction != dir_d_reg) begin
      dir_wait_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Translator position
  logic [6:0] pos_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_reg <= srh_pkg::POS_RST;
    end else if (stall_run_evt) begin
      pos_reg <= direction ? pos_reg - srh_pkg::BACK_135 : pos_reg + srh_pkg::BACK_135;
    end else if (step_ok) begin
      pos_reg <= direction ? pos_reg + step_size : pos_reg - step_size;
    end
  end

  assign position_o = pos_reg;

  // ==========================================================================
  // Undervoltage flags and step loss
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      uv_flag_reg <= 3'h0;
    end else begin
      uv_flag_reg <= uv_live | (uv_flag_reg & {3{!rd_stat1}});
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lose_reg <= 1'b0;
    end else begin
      lose_reg <= step_lost || (lose_reg && !rd_stat1);
    end
  end

  // Only step triggers count; direction and mode edits never reach here
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      loss_cnt_reg <= 7'h00;
    end else if (step_lost && loss_cnt_reg != srh_pkg::LOSS_MAX) begin
      loss_cnt_reg <= loss_cnt_reg + 7'h01;
    end else if (rd_stat4 && !step_lost) begin
      loss_cnt_reg <= 7'h00;
    end
  end

  // ==========================================================================
  // Current amplitude, boost and bridges
  logic [3:0] amp_reg;
  logic       duty_zero_reg;
  logic       bridge_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      amp_reg <= 4'h0;
    end else if (pwm_period_i) begin
      amp_reg <= run_mode ? run_cur : hold_cur;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boost_reg     <= 1'b0;
      duty_zero_reg <= 1'b0;
      bridge_reg    <= 1'b0;
    end else begin
      boost_reg     <= ctrl0_reg[srh_pkg::BOOST_BIT] && !tw_live;
      duty_zero_reg <= !run_mode && hold_cur == 4'h0;
      bridge_reg    <= motor_en_reg && !sleep_i;
    end
  end

  assign coil_amp_o        = amp_reg;
  assign boost_active_o    = boost_reg;
  assign duty_zero_o       = duty_zero_reg;
  assign bridge_en_o       = bridge_reg;
  assign uv1_index_o       = ctrl1_reg[srh_pkg::UV1_IDX_LSB +: 4];
  assign uv2_index_o       = ctrl1_reg[srh_pkg::UV2_IDX_LSB +: 4];
  assign emf_gain_select_o = ctrl2_reg[srh_pkg::GAIN_BIT];

  // ==========================================================================
  // Error line, open drain
  logic err_any;
  logic err_oe_reg;

  assign err_any = (uv_flag_reg[0] && irqen_reg[srh_pkg::IE_UV1])
                || (uv_flag_reg[1] && irqen_reg[srh_pkg::IE_UV2])
                || (uv_flag_reg[2] && irqen_reg[srh_pkg::IE_UV3])
                || lose_reg || stall_reg
                || (ready_reg && irqen_reg[srh_pkg::IE_EMF]);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_oe_reg <= 1'b0;
    end else begin
      err_oe_reg <= err_any;
    end
  end

  assign error_out_n_o    = 1'b0;
  assign error_out_n_oe_o = err_oe_reg;

  // ==========================================================================
  // Read port
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (re_i) begin
      unique case (addr_i)
        srh_pkg::A_CTRL0: rdata_o <= {ctrl0_reg[15], motor_en_reg, soft_step_reg, ctrl0_reg[12:0]};
        srh_pkg::A_CTRL1: rdata_o <= ctrl1_reg;
        srh_pkg::A_CTRL2: rdata_o <= ctrl2_reg;
        srh_pkg::A_IRQEN: rdata_o <= {10'h000, irqen_reg};
        srh_pkg::A_STAT1: rdata_o <= {7'h00, !err_wire_reg, lose_reg, uv_flag_reg,
                                      run_mode, boost_reg, rh_pin, stall_reg};
        srh_pkg::A_STAT4: rdata_o <= {1'b0, loss_cnt_reg, ready_reg, emf_coil_reg,
                                      emf_sign_reg, emf_code_reg};
        default:          rdata_o <= 16'h0000;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_stall_seen;
    stall_run_evt ##1 stall_reg;
  endsequence

  sequence s_lost_step;
    step_lost ##1 lose_reg;
  endsequence

  chk_stall_pulls_err: assert property (s_stall_seen |-> ##1 err_oe_reg)
    else $error("stall did not drive the error line");

  chk_lost_step_err: assert property (s_lost_step |-> ##1 error_out_n_oe_o)
    else $error("lost step did not drive the error line");

  chk_loss_saturate: assert property (loss_cnt_reg == srh_pkg::LOSS_MAX && step_lost
                                      |=> loss_cnt_reg == srh_pkg::LOSS_MAX)
    else $error("step loss counter wrapped");

  chk_uv3_motor_off: assert property (uv_live[2] |=> !motor_en_reg ##1 !bridge_en_o)
    else $error("motor stayed enabled at level three");

  chk_hold_keeps_pos: assert property (!run_mode |=> $stable(pos_reg))
    else $error("position moved in hold mode");

  chk_backstep_size: assert property (stall_run_evt |=> pos_reg == ($past(direction)
                                      ? 7'($past(pos_reg) - srh_pkg::BACK_135)
                                      : 7'($past(pos_reg) + srh_pkg::BACK_135)))
    else $error("backstep was not 135 degrees");

  chk_stall_read_clr: assert property (rd_stat1 && !stall_run_evt && !stall_hold_evt
                                       |=> !stall_reg)
    else $error("status read did not clear stall");

  chk_amp_on_period: assert property (pwm_period_i && run_mode
                                      |=> coil_amp_o == $past(run_cur))
    else $error("run current not applied at period");

  chk_boost_thermal: assert property (tw_live |=> !boost_active_o)
    else $error("boost active above thermal warning");

  chk_ready_on_eval: assert property (eval |=> ready_reg)
    else $error("result ready not flagged");

  chk_no_eval_fast: assert property (measured_speed_i > speed_threshold |-> !eval && !smp)
    else $error("measurement above speed threshold");

endmodule : srh_supervisor

// *** test/srh_mcu_side.sv ***
`timescale 1ns/1ns
// ==========================================================
// Error wire seen by the controller: pull-up, open drain
module srh_mcu_side (
  input  wire logic pull_low_i,
  output logic      wire_lvl_o
);
  // Released line floats to the pull-up level
  assign wire_lvl_o = pull_low_i ? 1'b0 : 1'b1;
endmodule : srh_mcu_side

// *** test/test_srh_supervisor.sv ***
`timescale 1ns/1ns
module test_srh_supervisor;
  logic clk_i = 0, rst_i = 1, we_i = 0, re_i = 0, rh = 0, stp = 0, dir = 0;
  logic tw = 0, slp = 0, pwm = 0, zc = 0, oe, errw, bst, bren, dz, gs;
  logic [2:0] addr = 0, uv = 0;
  logic [15:0] wd = 0, rdata, d;
  logic [6:0] pos;
  logic [3:0] amp, i1, i2;
  logic [7:0] spd = 0;
  srh_pkg::srh_emf_t emf = '0;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  srh_supervisor i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wd),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata), .run_hold_pin_i(rh),
    .step_pulse_pin_i(stp), .dir_pin_i(dir), .uv_level_i(uv), .thermal_warn_i(tw),
    .sleep_i(slp), .pwm_period_i(pwm), .zc_active_i(zc), .emf_i(emf),
    .measured_speed_i(spd), .error_out_n_i(errw), .error_out_n_o(),
    .error_out_n_oe_o(oe), .position_o(pos), .coil_amp_o(amp),
    .boost_active_o(bst), .bridge_en_o(bren), .duty_zero_o(dz),
    .uv1_index_o(i1), .uv2_index_o(i2), .emf_gain_select_o(gs));
  srh_mcu_side i_mcu (.pull_low_i(oe), .wire_lvl_o(errw));
  // ==========================================================
  // Bus and check tasks
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tk
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk_i); we_i <= 1; addr <= a; wd <= v;
    @(posedge clk_i); we_i <= 0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge clk_i); re_i <= 1; addr <= a;
    @(posedge clk_i); re_i <= 0;
    #1 d = rdata;
  endtask : rd
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic zphase(input logic [4:0] c);
    @(posedge clk_i); zc <= 1;
    @(posedge clk_i); emf <= '{1'b1, 1'b0, 1'b0, 1'b0, c};
    @(posedge clk_i); emf.valid <= 0;
    @(posedge clk_i); zc <= 0;
    tk(3);
  endtask : zphase
  task automatic give_verdict;
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // Ceiling well above the whole sequence
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict;
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    rd(srh_pkg::A_CTRL0); chk(d, srh_pkg::CTRL0_RST);
    rd(3'h6); chk(d, 16'h0000);
    wr(srh_pkg::A_CTRL0, 16'h2135); tk(3);
    chk({15'h0, pos === 7'h01 || pos === 7'h7f}, 16'h0001);
    wr(srh_pkg::A_CTRL0, 16'h2335); tk(3); chk({9'h0, pos}, 16'h0000);
    @(posedge clk_i); pwm <= 1; @(posedge clk_i); pwm <= 0; tk(2);
    chk({12'h0, amp}, 16'h0005);
    rd(srh_pkg::A_STAT1); chk(d & 16'h000a, 16'h0008);
    wr(srh_pkg::A_CTRL0, 16'h2035); tk(3); chk({9'h0, pos}, 16'h0000);
    @(posedge clk_i); pwm <= 1; @(posedge clk_i); pwm <= 0; tk(2);
    chk({12'h0, amp}, 16'h0003);
    wr(srh_pkg::A_CTRL0, 16'h0005); tk(3); chk({15'h0, dz}, 16'h0001);
    wr(srh_pkg::A_CTRL0, 16'h8135); tk(3); chk({15'h0, bst}, 16'h0001);
    @(posedge clk_i); tw <= 1; tk(6); chk({15'h0, bst}, 16'h0000);
    @(posedge clk_i); tw <= 0;
    wr(srh_pkg::A_CTRL0, 16'h4135); tk(2); chk({15'h0, bren}, 16'h0001);
    wr(srh_pkg::A_IRQEN, 16'h0001); uv <= 3'h1; tk(6);
    chk({14'h0, oe, bren}, 16'h0003);
    rd(srh_pkg::A_STAT1); chk(d & 16'h0010, 16'h0010);
    @(posedge clk_i); uv <= 3'h0; tk(4); rd(srh_pkg::A_STAT1); tk(3);
    chk({15'h0, oe}, 16'h0000);
    @(posedge clk_i); uv <= 3'h4; tk(6); chk({15'h0, bren}, 16'h0000);
    wr(srh_pkg::A_CTRL0, 16'h4135); tk(2); chk({15'h0, bren}, 16'h0000);
    @(posedge clk_i); uv <= 3'h0; tk(4); rd(srh_pkg::A_STAT1);
    wr(srh_pkg::A_CTRL0, 16'h4135); tk(2); chk({15'h0, bren}, 16'h0001);
    rd(srh_pkg::A_STAT4);
    wr(srh_pkg::A_IRQEN, 16'h0004); uv <= 3'h2; tk(4);
    repeat (130) begin
      @(posedge clk_i); stp <= 1; repeat (3) @(posedge clk_i); stp <= 0; tk(2);
    end
    chk({8'h0, oe, pos}, 16'h0080);
    rd(srh_pkg::A_STAT4); chk(d & 16'h7f00, 16'h7f00);
    @(posedge clk_i); uv <= 3'h0; tk(4); rd(srh_pkg::A_STAT1); tk(3);
    wr(srh_pkg::A_CTRL1, 16'h0021); wr(srh_pkg::A_CTRL2, 16'h0024); tk(1);
    chk({7'h0, gs, i2, i1}, 16'h0121);
    zphase(5'h06); zphase(5'h06);
    rd(srh_pkg::A_STAT1); chk({13'h0, d[8], d[0], oe}, 16'h0007);
    chk({9'h0, pos}, 16'h0030);
    rd(srh_pkg::A_STAT4); chk(d & 16'h00ff, 16'h0086);
    tk(3); chk({15'h0, oe}, 16'h0000);
    rd(srh_pkg::A_STAT1); chk(d & 16'h0001, 16'h0000);
    @(posedge clk_i); spd <= 8'h01; zphase(5'h1f);
    rd(srh_pkg::A_STAT4); chk(d & 16'h00ff, 16'h0006);
    give_verdict;
  end
endmodule : test_srh_supervisor
